// file: rtl/dcsl_pkg.sv
// Purpose: shared constants and types for the dual channel stop logic
// Assumes: 200 MHz control clock
// Notes: terminal function codes are the selectable output assignments
package dcsl_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HOLD_TIME_US = 2000;
  localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1_000_000) * HOLD_TIME_US;
  localparam int unsigned BAUD_MAX = 38400;
  localparam int unsigned BAUD_DIV_MIN = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TERM_SEL = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_FAULT = 4'h3;
  localparam logic [3:0] REG_SERIAL = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h5;
  localparam logic [3:0] REG_MON = 4'h6;
  // function codes
  localparam logic [7:0] FN_RUN = 8'h00;
  localparam logic [7:0] FN_FREQ = 8'h01;
  localparam logic [7:0] FN_STOP_POS = 8'h50;
  localparam logic [7:0] FN_HEALTH_POS = 8'h51;
  localparam logic [7:0] FN_STOP_NEG = 8'hB4;
  localparam logic [7:0] FN_HEALTH_NEG = 8'hB5;
  // reset values
  localparam logic [23:0] TERM_SEL_RST = 24'h00_0100;
  localparam logic [15:0] BAUD_DIV_RST = 16'h1459;
  localparam logic [7:0] CTRL_RST = 8'h00;
  typedef enum logic [1:0] {DCSL_PROTO_DRIVE, DCSL_PROTO_MODBUS} dcsl_proto_e;
  typedef enum logic [2:0] {
    DCSL_FLT_NONE, DCSL_FLT_A, DCSL_FLT_B, DCSL_FLT_C, DCSL_FLT_D
  } dcsl_fault_e;
  typedef struct packed {
    logic run_flag;
    logic freq_flag;
    logic stop_flag;
    logic health_flag;
  } dcsl_sig_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } dcsl_bus_s;
endpackage

// file: rtl/dcsl_filter.sv
// Purpose: pin synchroniser and hold-time filter for one stop channel
// Assumes: pin is asynchronous to clk
// Notes: recognised level changes only after HOLD cycles of stable input
`timescale 1ns/1ps
module dcsl_filter
  import dcsl_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  localparam int unsigned CW = $clog2(HOLD + 1);
  logic s1_q, s2_q, s3_q;
  logic [CW-1:0] cnt_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // count agreeing samples that differ from the recognised level
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      level <= 1'b0;
    end
    else if ((s2_q != s3_q) || (s3_q == level))
      cnt_q <= '0;
    else if (cnt_q == CW'(HOLD - 1))
    begin
      cnt_q <= '0;
      level <= s3_q;
    end
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule // dcsl_filter

// file: rtl/dcsl_baud.sv
// Purpose: bit-rate enable divider for the operator port
// Assumes: divisor written by software
// Notes: emits one-cycle enable pulses
`timescale 1ns/1ps
module dcsl_baud
  import dcsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] div,
  output logic tick
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q >= div - 16'h0001)
    begin
      cnt_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // dcsl_baud

// file: rtl/dcsl_top.sv
// Purpose: safety stop decision logic with status terminals and operator port control
// Assumes: channel pins high when closed to common; power_ok from supply monitor
// Notes: fault sources arrive as level inputs from the safety circuit monitors
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module dcsl_top
  import dcsl_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stop_channel_one,
  input wire logic stop_channel_two,
  input wire logic power_ok,
  input wire logic [3:0] fault_src,
  input wire logic run_state,
  input wire logic freq_state,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic drive_enable,
  output logic run_terminal_on,
  output logic freq_detect_terminal_on,
  output logic third_terminal_on,
  output logic [2:0] display_code,
  output logic stop_active_indication,
  output logic serial_tick,
  output logic [1:0] serial_proto,
  output logic serial_multidrop,
  output logic host_run_cmd
);
  logic pwr_a_q, pwr_b_q, pwr_c_q, pwr_q;
  logic ch1_lvl, ch2_lvl;
  logic mismatch, fault_any;
  dcsl_sig_s sig;
  dcsl_fault_e fault_d;
  logic [7:0] sel_run_q, sel_freq_q, sel_third_q;
  logic [15:0] baud_div_q;
  logic proto_q;
  logic run_cmd_q;
  logic [7:0] ctrl_q;
  logic tick;

  dcsl_filter #(.HOLD(HOLD)) u_ch1 (
    .clk(clk),
    .rst_b(rst_b),
    .pin(stop_channel_one),
    .level(ch1_lvl)
  );
  dcsl_filter #(.HOLD(HOLD)) u_ch2 (
    .clk(clk),
    .rst_b(rst_b),
    .pin(stop_channel_two),
    .level(ch2_lvl)
  );
  dcsl_baud u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .div(baud_div_q),
    .tick(tick)
  );

  // power monitor synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pwr_a_q <= 1'b0;
      pwr_b_q <= 1'b0;
      pwr_c_q <= 1'b0;
      pwr_q <= 1'b0;
    end
    else
    begin
      pwr_a_q <= power_ok;
      pwr_b_q <= pwr_a_q;
      pwr_c_q <= pwr_b_q;
      if (pwr_b_q == pwr_c_q)
        pwr_q <= pwr_c_q;
    end
  end

  // maps a terminal selection code onto the internal signals
  function automatic logic term_out(input logic [7:0] code, input dcsl_sig_s s);
    unique case (code)
      FN_RUN: term_out = s.run_flag;
      FN_FREQ: term_out = s.freq_flag;
      FN_STOP_POS: term_out = s.stop_flag;
      FN_STOP_NEG: term_out = !s.stop_flag;
      FN_HEALTH_POS: term_out = s.health_flag;
      FN_HEALTH_NEG: term_out = !s.health_flag;
      default: term_out = 1'b0;
    endcase
  endfunction

  assign mismatch = ch1_lvl != ch2_lvl;
  assign fault_any = mismatch || (|fault_src);

  always_comb
  begin
    sig.run_flag = run_state && !ctrl_q[0];
    sig.freq_flag = freq_state;
    sig.stop_flag = !fault_any && !ch1_lvl && !ch2_lvl;
    sig.health_flag = !fault_any;
  end

  // four distinct indications, mismatch reported as the first
  always_comb
  begin
    if (mismatch || fault_src[0])
      fault_d = DCSL_FLT_A;
    else if (fault_src[1])
      fault_d = DCSL_FLT_B;
    else if (fault_src[2])
      fault_d = DCSL_FLT_C;
    else if (fault_src[3])
      fault_d = DCSL_FLT_D;
    else
      fault_d = DCSL_FLT_NONE;
  end

  // drive gate and status terminals
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      drive_enable <= 1'b0;
      run_terminal_on <= 1'b0;
      freq_detect_terminal_on <= 1'b0;
      third_terminal_on <= 1'b0;
    end
    else if (!pwr_q)
    begin
      drive_enable <= 1'b0;
      run_terminal_on <= 1'b0;
      freq_detect_terminal_on <= 1'b0;
      third_terminal_on <= 1'b0;
    end
    else
    begin
      drive_enable <= !fault_any && ch1_lvl && ch2_lvl;
      run_terminal_on <= term_out(sel_run_q, sig);
      freq_detect_terminal_on <= term_out(sel_freq_q, sig);
      third_terminal_on <= term_out(sel_third_q, sig);
    end
  end

  // operator display
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      display_code <= 3'h0;
      stop_active_indication <= 1'b0;
    end
    else
    begin
      display_code <= fault_d;
      stop_active_indication <= pwr_q && sig.stop_flag;
    end
  end

  // register writes
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sel_run_q <= TERM_SEL_RST[7:0];
      sel_freq_q <= TERM_SEL_RST[15:8];
      sel_third_q <= TERM_SEL_RST[23:16];
      baud_div_q <= BAUD_DIV_RST;
      proto_q <= 1'b0;
      ctrl_q <= CTRL_RST;
    end
    else if (wr)
    begin
      unique case (addr)
        REG_CTRL: ctrl_q <= wdata[7:0];
        REG_TERM_SEL:
        begin
          sel_run_q <= wdata[7:0];
          sel_freq_q <= wdata[15:8];
          sel_third_q <= wdata[23:16];
        end
        REG_SERIAL:
        begin
          // clamp divisor so the rate never exceeds the port maximum
          if (wdata[15:0] < 16'(BAUD_DIV_MIN))
            baud_div_q <= 16'(BAUD_DIV_MIN);
          else
            baud_div_q <= wdata[15:0];
          proto_q <= wdata[16];
        end
        default: ;
      endcase
    end
  end

  // host run command; a standing fault wins over a host write
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      run_cmd_q <= 1'b0;
    else if (fault_any)
      run_cmd_q <= 1'b0;
    else if (wr && (addr == REG_CMD))
      run_cmd_q <= wdata[0];
  end

  // register reads, data stand the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata <= '0;
    else if (rd)
    begin
      unique case (addr)
        REG_CTRL: rdata <= {24'h00_0000, ctrl_q};
        REG_TERM_SEL: rdata <= {8'h00, sel_third_q, sel_freq_q, sel_run_q};
        REG_STATUS: rdata <= {26'h000_0000, pwr_q, ch2_lvl, ch1_lvl, drive_enable,
                              sig.health_flag, sig.stop_flag};
        REG_FAULT: rdata <= {25'h000_0000, fault_src, fault_d};
        REG_SERIAL: rdata <= {15'h0000, proto_q, baud_div_q};
        REG_CMD: rdata <= {31'h0000_0000, run_cmd_q};
        REG_MON: rdata <= {29'h0000_0000, third_terminal_on, freq_detect_terminal_on,
                           run_terminal_on};
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // serial port control
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      serial_tick <= 1'b0;
      serial_proto <= 2'h0;
      serial_multidrop <= 1'b0;
      host_run_cmd <= 1'b0;
    end
    else
    begin
      serial_tick <= tick;
      serial_proto <= proto_q ? DCSL_PROTO_MODBUS : DCSL_PROTO_DRIVE;
      serial_multidrop <= 1'b1;
      host_run_cmd <= run_cmd_q && drive_enable;
    end
  end
endmodule // dcsl_top

// file: dv/dcsl_top_assertions.sv
// Purpose: port checker for the stop decision logic
// Assumes: HOLD equals the value given to the design
// Notes: bound into dcsl_top
`timescale 1ns/1ps
module dcsl_top_assertions
  import dcsl_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stop_channel_one,
  input wire logic stop_channel_two,
  input wire logic power_ok,
  input wire logic [3:0] fault_src,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic drive_enable,
  input wire logic run_terminal_on,
  input wire logic freq_detect_terminal_on,
  input wire logic third_terminal_on,
  input wire logic [2:0] display_code,
  input wire logic stop_active_indication,
  input wire logic serial_multidrop
);
  int unsigned both_q;
  // cycles both pins have been closed, saturating
  always_ff @(posedge clk)
  begin
    if (!(stop_channel_one && stop_channel_two))
      both_q <= 0;
    else if (both_q < HOLD)
      both_q <= both_q + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_held;
    both_q >= HOLD;
  endsequence
  sequence s_fault;
    (fault_src != 4'h0) [*3];
  endsequence
  AST_HOLD: assert property ($rose(drive_enable) |-> s_held)
    else $error("drive rose before hold time");
  AST_FLT_OFF: assert property (s_fault |-> !drive_enable && display_code != 3'h0)
    else $error("fault did not stop drive");
  AST_DISP_RANGE: assert property (display_code <= 3'h4)
    else $error("bad display code");
  AST_DISP_EXCL: assert property (display_code != 3'h0 |-> !drive_enable && !stop_active_indication)
    else $error("fault shown with drive or stop");
  AST_SA_EXCL: assert property (stop_active_indication |-> !drive_enable && display_code == 3'h0)
    else $error("stop shown with drive or fault");
  AST_PWR: assert property ((!power_ok) [*6] |-> !drive_enable && !run_terminal_on
    && !freq_detect_terminal_on && !third_terminal_on)
    else $error("outputs on without power");
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  AST_MDROP: assert property ($past(rst_b) |-> serial_multidrop)
    else $error("multidrop off");
endmodule // dcsl_top_assertions
bind dcsl_top dcsl_top_assertions #(.HOLD(HOLD)) u_chk (.clk, .rst_b, .stop_channel_one,
  .stop_channel_two, .power_ok, .fault_src, .rd, .rdata, .drive_enable, .run_terminal_on,
  .freq_detect_terminal_on, .third_terminal_on, .display_code, .stop_active_indication,
  .serial_multidrop);

// file: dv/dcsl_relay_model.sv
// Purpose: safety relay module driving both stop channels
// Assumes: a closed contact reads 1
// Notes: open_one opens contact one alone, for pulse and mismatch cases
`timescale 1ns/1ps
module dcsl_relay_model
(
  input wire logic clk,
  input wire logic close_req,
  input wire logic open_one,
  output logic stop_channel_one,
  output logic stop_channel_two
);
  logic cl_q;
  initial
  begin
    cl_q = 1'b0;
    stop_channel_one = 1'b0;
    stop_channel_two = 1'b0;
  end
  // contact two lags contact one by a cycle, as real contacts do not close together
  always @(posedge clk)
  begin
    cl_q <= close_req;
    stop_channel_one <= close_req && !open_one;
    stop_channel_two <= cl_q;
  end
endmodule // dcsl_relay_model

// file: dv/testbench.sv
// Purpose: self-checking bench for the stop decision logic
// Assumes: HOLD shortened to 8 cycles
// Notes: random fault patterns and terminal flags from a fixed seed
`timescale 1ns/1ps
module testbench;
  import dcsl_pkg::*;
  localparam int unsigned HOLD = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_ok = 1'b1;
  logic [3:0] fault_src = 4'h0;
  logic run_state = 1'b0;
  logic freq_state = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic close_req = 1'b0;
  logic open_one = 1'b0;
  logic ch1, ch2, drv, run_t, frq_t, thr_t, sa, tick, mdrop, hrun, t;
  logic run_p, freq_p;
  logic [31:0] rdata, rv;
  logic [2:0] disp;
  logic [1:0] proto;
  logic [3:0] f;
  logic [7:0] codes [4] = '{FN_HEALTH_POS, FN_HEALTH_NEG, FN_STOP_POS, FN_STOP_NEG};
  int bad_count = 0;
  int tests_run = 0;
  int seed = 73176;
  int n;
  always #2.5 clk = ~clk;
  always @(posedge clk) {run_state, freq_state} <= 2'($random(seed));
  // flags as the design sampled them at the last edge
  always @(posedge clk) {run_p, freq_p} <= {run_state, freq_state};
  dcsl_relay_model u_dcsl_relay_model (.clk(clk), .close_req(close_req), .open_one(open_one),
    .stop_channel_one(ch1), .stop_channel_two(ch2));
  dcsl_top #(.HOLD(HOLD)) u_dcsl_top (.clk(clk), .rst_b(rst_b), .stop_channel_one(ch1),
    .stop_channel_two(ch2), .power_ok(power_ok), .fault_src(fault_src), .run_state(run_state),
    .freq_state(freq_state), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .drive_enable(drv), .run_terminal_on(run_t), .freq_detect_terminal_on(frq_t),
    .third_terminal_on(thr_t), .display_code(disp), .stop_active_indication(sa),
    .serial_tick(tick), .serial_proto(proto), .serial_multidrop(mdrop), .host_run_cmd(hrun));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    cyc(8);
    rst_b <= 1'b1;
    cyc(HOLD + 10);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    cyc(1);
    while (tick !== 1'b1)
    begin
      c++;
      if (c > 6000)
      begin
        bad_count++;
        report_and_stop();
      end
      cyc(1);
    end
  endtask
  function automatic logic [31:0] exp_st(logic c1, logic c2, logic p, logic fl);
    logic h;
    h = p && !fl && (c1 == c2);
    return {26'h0, p, c2, c1, h && c1, h, h && !c1};
  endfunction
  function automatic logic term(logic [7:0] c, logic h, logic s);
    case (c)
      FN_HEALTH_POS: return h;
      FN_HEALTH_NEG: return !h;
      FN_STOP_POS: return s;
      FN_STOP_NEG: return !s;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [2:0] exp_disp(logic [3:0] fl);
    for (int i = 0; i < 4; i++)
      if (fl[i]) return 3'(i + 1);
    return 3'h0;
  endfunction
  initial
  begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    do_reset();
    chk("sa", sa, 1);
    rreg(REG_STATUS, rv);
    chk("st", rv, exp_st(0, 0, 1, 0));
    rreg(4'hF, rv);
    chk("unmap", rv, 0);
    rreg(REG_TERM_SEL, rv);
    chk("tsel", rv, {8'h00, TERM_SEL_RST});
    chk("runsel", {run_t, frq_t, thr_t}, {run_p, freq_p, run_p});
    wreg(REG_CTRL, 1);
    cyc(2);
    chk("mask", {run_t, frq_t, thr_t}, {1'b0, freq_p, 1'b0});
    rreg(REG_CTRL, rv);
    chk("ctrl", rv, 1);
    for (int k = 0; k < 8; k++)
    begin
      close_req <= k[0];
      cyc(HOLD + 10);
      wreg(REG_TERM_SEL, {8'h00, {3{codes[k / 2]}}});
      cyc(3);
      t = term(codes[k / 2], 1'b1, !k[0]);
      chk("trm", {run_t, frq_t, thr_t}, {3{t}});
      chk("drv", {drv, sa}, {k[0], !k[0]});
      rreg(REG_MON, rv);
      chk("mon", rv, {29'h0, {3{t}}});
    end
    rreg(REG_STATUS, rv);
    chk("st", rv, exp_st(1, 1, 1, 0));
    open_one <= 1'b1;
    cyc(HOLD - 3);
    open_one <= 1'b0;
    cyc(4);
    chk("pulse", drv, 1);
    open_one <= 1'b1;
    cyc(HOLD + 10);
    chk("mis", {drv, sa, disp}, 5'h01);
    rreg(REG_STATUS, rv);
    chk("mst", rv, exp_st(0, 1, 1, 0));
    open_one <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      do_reset();
      close_req <= !k[0];
      cyc(HOLD + 10);
      wreg(REG_TERM_SEL, {8'h00, {3{FN_HEALTH_POS}}});
      wreg(REG_CMD, 1);
      cyc(2);
      chk("hrun", hrun, !k[0]);
      f = (k < 4) ? 4'(1 << k) : 4'($random(seed));
      if (f == 4'h0)
        f = 4'h8;
      fault_src <= f;
      cyc(4);
      chk("flt", {drv, sa, run_t, hrun, disp}, {4'h0, exp_disp(f)});
      rreg(REG_FAULT, rv);
      chk("fst", rv, {25'h0, f, exp_disp(f)});
      fault_src <= 4'h0;
    end
    do_reset();
    wreg(REG_TERM_SEL, {8'h00, {3{FN_HEALTH_POS}}});
    power_ok <= 1'b0;
    cyc(8);
    chk("pwr", {drv, run_t, frq_t, thr_t}, 0);
    power_ok <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wreg(REG_SERIAL, {15'h0, k[0], 16'h0010});
      cyc(2);
      chk("proto", proto, k);
      chk("mdrop", mdrop, 1);
      rreg(REG_SERIAL, rv);
      chk("ser", rv, {15'h0, k[0], 16'(BAUD_DIV_MIN)});
      wait_tick(n);
      wait_tick(n);
      chk("baud", n, BAUD_DIV_MIN - 1);
    end
    report_and_stop();
  end
endmodule // testbench
